//--- src/tdrec_timer.sv
// 8-bit reload / event counter / input capture timer with APB registers
`timescale 1ns/100ps

module tdrec_timer (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        event_trigger_pin,
    output logic             timer_irq_flag,
    output logic             capture_status_flag,
    output logic             capture_error_flag,
    output logic             overflow_pulse
);
    // software-visible configuration
    logic [3:0]  port_function_select_two;
    logic [3:0]  module_clock_standby_one;
    logic [3:0]  timer_mode_select;
    logic [3:0]  mode_pending;
    logic [3:0]  mode_delay_cnt;
    logic [2:0]  edge_capture_select;
    logic [3:0]  reload_value_low;
    logic [3:0]  reload_value_high;

    // counter core and read digits
    logic [3:0]  count_read_low;
    logic [3:0]  capture_high;
    logic [7:0]  count;
    logic        capt_mode_q;

    // clock divider, prescaler and pin synchroniser
    logic [3:0]  instr_cnt;
    logic        instr_tick;
    logic [10:0] prescale;
    logic        pin_meta;
    logic        pin_sync;
    logic        pin_prev;
    logic        edge_raw;
    logic        edge_seen;

    // count qualifiers
    logic        int_tick;
    logic        count_tick;
    logic        capt_mode;
    logic        capt_event;
    logic        overflow;
    logic        clk_on;

    // bus decode
    logic        setup;
    logic        access;
    logic        wr;
    logic [7:0]  idx;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    // zero-wait slave: data is prepared during the setup cycle
    // every transfer is one setup and one access cycle; read data is
    // registered at the setup edge so it stands through the access cycle,
    // and the upper-digit read latch acts at that same edge
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign pready = access;
    assign wr     = access & pwrite;
    assign idx    = {2'h0, paddr[7:2]};

    // register select for read data and unmapped addresses
    // byte address is four times the index:
    //   0x28 port function, bit 0 routes the pin to the event input
    //   0x34 clock standby, bit 0 stops the timer clock
    //   0x60 mode, bit 3 reload, bits 2:0 source (0..6 internal, 7 pin)
    //   0x64 edge, bits 1:0 none/fall/rise/both, bit 2 capture operation
    //   0x68 / 0x6C low / high digit; writes load, reads show the count
    //   0x70 flags, bit 0 irq, bit 1 status, bit 2 error; write 0 clears
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (idx == tdrec_pkg::IDX_PORT_FUNC) begin
            next_prdata = 32'h0000_0000; // write-only
        end else if (idx == tdrec_pkg::IDX_CLK_STBY) begin
            next_prdata = 32'h0000_0000;
        end else if (idx == tdrec_pkg::IDX_MODE_SEL) begin
            next_prdata = 32'h0000_0000;
        end else if (idx == tdrec_pkg::IDX_EDGE_SEL) begin
            next_prdata = 32'h0000_0000;
        end else if (idx == tdrec_pkg::IDX_DIGIT_LOW) begin
            next_prdata = {28'h0, count_read_low};
        end else if (idx == tdrec_pkg::IDX_DIGIT_HIGH) begin
            // capture mode shows the frozen value, else the live count
            next_prdata = capt_mode ? {28'h0, capture_high}
                                    : {28'h0, count[7:4]};
        end else if (idx == tdrec_pkg::IDX_FLAGS) begin
            next_prdata = {29'h0, capture_error_flag, capture_status_flag,
                           timer_irq_flag};
        end else begin
            next_pslverr = 1'b1;
        end
    end

    // read data and error register
    // write transfers return zero so stale read data never shows
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // write-only configuration registers
    // unused upper bits of port and standby are stored but never read
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            port_function_select_two <= tdrec_pkg::RST_PORT_FUNC;
            module_clock_standby_one <= tdrec_pkg::RST_CLK_STBY;
            edge_capture_select      <= tdrec_pkg::RST_EDGE_SEL;
            reload_value_low         <= tdrec_pkg::RST_WR_LOW;
        end else if (wr) begin
            if (idx == tdrec_pkg::IDX_PORT_FUNC) begin
                port_function_select_two <= pwdata[3:0];
            end else if (idx == tdrec_pkg::IDX_CLK_STBY) begin
                module_clock_standby_one <= pwdata[3:0];
            end else if (idx == tdrec_pkg::IDX_EDGE_SEL) begin
                edge_capture_select <= pwdata[2:0];
            end else if (idx == tdrec_pkg::IDX_DIGIT_LOW) begin
                reload_value_low <= pwdata[3:0];
            end
        end
    end

    // upper write digit has no reset value
    // reload mode needs an upper write before the first overflow
    always_ff @(posedge sys_clk) begin
        if (wr && idx == tdrec_pkg::IDX_DIGIT_HIGH) begin
            reload_value_high <= pwdata[3:0];
        end
    end

    // mode register is applied two instruction cycles after the write
    // the old mode keeps running meanwhile; a second write inside the
    // delay restarts it, and software reloads the count afterwards
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timer_mode_select <= tdrec_pkg::RST_MODE_SEL;
            mode_pending      <= tdrec_pkg::RST_MODE_SEL;
            mode_delay_cnt    <= 4'h0;
        end else if (wr && idx == tdrec_pkg::IDX_MODE_SEL) begin
            mode_pending   <= pwdata[3:0];
            mode_delay_cnt <= 4'(tdrec_pkg::MODE_DELAY_CYC);
        end else if (mode_delay_cnt != 4'h0) begin
            mode_delay_cnt <= mode_delay_cnt - 4'h1;
            if (mode_delay_cnt == 4'h1) begin
                timer_mode_select <= mode_pending;
            end
        end
    end

    // instruction-cycle divider and prescaler; stopped in standby
    // one instruction cycle is four system clocks
    assign clk_on = ~module_clock_standby_one[tdrec_pkg::STBY_TIMER_BIT];
    assign instr_tick = clk_on &
                        (instr_cnt == 4'(tdrec_pkg::INSTR_CYCLES - 1));

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            instr_cnt <= 4'h0;
        end else if (!clk_on) begin
            instr_cnt <= 4'h0;
        end else if (instr_tick) begin
            instr_cnt <= 4'h0;
        end else begin
            instr_cnt <= instr_cnt + 4'h1;
        end
    end

    // prescaler runs from reset on; mode writes do not restart its phase
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prescale <= 11'h000;
        end else if (instr_tick) begin
            prescale <= prescale + 11'h001;
        end
    end

    // divide ratio per source code: 2048, 512, 128, 32, 8, 4, 2 cycles
    // one shared prescaler keeps the logic small, first tick not aligned
    always_comb begin
        case (timer_mode_select[2:0])
            3'h0:    int_tick = instr_tick & (&prescale[10:0]);
            3'h1:    int_tick = instr_tick & (&prescale[8:0]);
            3'h2:    int_tick = instr_tick & (&prescale[6:0]);
            3'h3:    int_tick = instr_tick & (&prescale[4:0]);
            3'h4:    int_tick = instr_tick & (&prescale[2:0]);
            3'h5:    int_tick = instr_tick & (&prescale[1:0]);
            3'h6:    int_tick = instr_tick & prescale[0];
            default: int_tick = 1'b0;
        endcase
    end

    // pin synchroniser; resets high and follows the pin even while it serves another function
    // an edge acts three clocks after the pin moves
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
        end else begin
            pin_meta <= event_trigger_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // edge detect on synchronised levels only, once per edge; both-edge
    // mode needs the source to keep its levels apart, a pulse shorter
    // than the synchroniser depth can vanish without any count
    always_comb begin
        case (edge_capture_select[1:0])
            tdrec_pkg::EDGE_FALLING: edge_raw = pin_prev & ~pin_sync;
            tdrec_pkg::EDGE_RISING:  edge_raw = ~pin_prev & pin_sync;
            tdrec_pkg::EDGE_BOTH:    edge_raw = pin_prev ^ pin_sync;
            default:                 edge_raw = 1'b0;
        endcase
    end

    // a stopped timer or an unrouted pin drops every edge
    assign edge_seen = edge_raw & clk_on &
                       port_function_select_two[tdrec_pkg::PORT_EVENT_BIT];

    // capture needs the enable bit and a routed, clocked pin edge
    assign capt_mode = edge_capture_select[tdrec_pkg::EDGE_CAPT_BIT];
    assign capt_event = capt_mode & edge_seen;

    // count source: external edges only outside capture mode
    // limitation: in capture mode pin edges capture and never count
    always_comb begin
        if (timer_mode_select[2:0] == tdrec_pkg::SRC_EXTERNAL) begin
            count_tick = edge_seen & ~capt_mode;
        end else begin
            count_tick = int_tick;
        end
    end

    // a capture in the same tick clears the count instead of overflowing
    assign overflow = count_tick & (count == tdrec_pkg::COUNT_MAX) &
                      ~capt_event;

    // capture enable delayed one clock to find its rising edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            capt_mode_q <= 1'b0;
        end else begin
            capt_mode_q <= capt_mode;
        end
    end

    // counter; a software load wins over counting
    // priority: upper-digit load, capture entry clear, capture clear,
    // overflow reload, then plain counting; a load always sticks even
    // when an input tick lands in the same clock
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count <= tdrec_pkg::COUNT_ZERO;
        end else if (wr && idx == tdrec_pkg::IDX_DIGIT_HIGH) begin
            count <= {pwdata[3:0], reload_value_low};
        end else if (capt_mode && !capt_mode_q) begin
            count <= tdrec_pkg::COUNT_ZERO;
        end else if (capt_event) begin
            count <= tdrec_pkg::COUNT_ZERO;
        end else if (overflow) begin
            // free-running restarts at zero, reload at the written value
            count <= timer_mode_select[tdrec_pkg::MODE_RELOAD_BIT] ?
                     {reload_value_high, reload_value_low} :
                     tdrec_pkg::COUNT_ZERO;
        end else if (count_tick) begin
            count <= count + 8'h01;
        end
    end

    // read digits: capture freezes both, upper read latches lower
    // outside capture the latch keeps a two-digit read coherent
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_read_low <= 4'h0;
            capture_high   <= 4'h0;
        end else if (capt_event) begin
            count_read_low <= count[3:0];
            capture_high   <= count[7:4];
        end else if (setup && !pwrite && !capt_mode &&
                     idx == tdrec_pkg::IDX_DIGIT_HIGH) begin
            count_read_low <= count[3:0];
        end
    end

    // flags: hardware set wins over a software clear in the same cycle,
    // so an event is never lost to a clear that software issued too late
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timer_irq_flag <= 1'b0;
        end else if (overflow || capt_event) begin
            timer_irq_flag <= 1'b1;
        end else if (wr && idx == tdrec_pkg::IDX_FLAGS &&
                     !pwdata[tdrec_pkg::FLAG_IRQ_BIT]) begin
            timer_irq_flag <= 1'b0;
        end
    end

    // capture status: set by each capture, cleared by writing 0
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            capture_status_flag <= 1'b0;
        end else if (capt_event) begin
            capture_status_flag <= 1'b1;
        end else if (wr && idx == tdrec_pkg::IDX_FLAGS &&
                     !pwdata[tdrec_pkg::FLAG_CSF_BIT]) begin
            capture_status_flag <= 1'b0;
        end
    end

    // capture error: capture while status still set, or overflow in capture
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            capture_error_flag <= 1'b0;
        end else if ((capt_event && capture_status_flag) ||
                     (overflow && capt_mode)) begin
            capture_error_flag <= 1'b1;
        end else if (wr && idx == tdrec_pkg::IDX_FLAGS &&
                     !pwdata[tdrec_pkg::FLAG_CEF_BIT]) begin
            capture_error_flag <= 1'b0;
        end
    end

    // overflow strobe for neighbouring logic
    // one clock late, so it lines up with the irq flag it explains
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            overflow_pulse <= 1'b0;
        end else begin
            overflow_pulse <= overflow;
        end
    end
endmodule

//--- src/tdrec_pkg.sv
// constants shared by the event / capture timer
package tdrec_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PORT_FUNC  = 8'h0A;
    localparam logic [7:0] IDX_CLK_STBY   = 8'h0D;
    localparam logic [7:0] IDX_MODE_SEL   = 8'h18;
    localparam logic [7:0] IDX_EDGE_SEL   = 8'h19;
    localparam logic [7:0] IDX_DIGIT_LOW  = 8'h1A;
    localparam logic [7:0] IDX_DIGIT_HIGH = 8'h1B;
    localparam logic [7:0] IDX_FLAGS      = 8'h1C;

    // reset values
    localparam logic [3:0] RST_PORT_FUNC = 4'h0;
    localparam logic [3:0] RST_CLK_STBY  = 4'h0;
    localparam logic [3:0] RST_MODE_SEL  = 4'h0;
    localparam logic [2:0] RST_EDGE_SEL  = 3'h0;
    localparam logic [3:0] RST_WR_LOW    = 4'h0;
    localparam logic [7:0] COUNT_MAX     = 8'hFF;
    localparam logic [7:0] COUNT_ZERO    = 8'h00;

    // field positions
    localparam int MODE_RELOAD_BIT = 3;   // 1 reload, 0 free-running
    localparam int EDGE_CAPT_BIT   = 2;   // 1 input capture operation
    localparam int PORT_EVENT_BIT  = 0;   // 1 pin is the event input
    localparam int STBY_TIMER_BIT  = 0;   // 1 timer clock stopped
    localparam int FLAG_IRQ_BIT    = 0;
    localparam int FLAG_CSF_BIT    = 1;
    localparam int FLAG_CEF_BIT    = 2;

    // clock source codes in the low three mode bits
    localparam logic [2:0] SRC_EXTERNAL = 3'h7;

    // edge select codes
    localparam logic [1:0] EDGE_NONE    = 2'h0;
    localparam logic [1:0] EDGE_FALLING = 2'h1;
    localparam logic [1:0] EDGE_RISING  = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    // timing: 40 MHz system clock, one instruction cycle in ns
    localparam int SYS_CLK_NS     = 25;
    localparam int INSTR_NS       = 100;
    localparam int INSTR_CYCLES   = (INSTR_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int MODE_DELAY_INS = 2;
    localparam int MODE_DELAY_CYC = MODE_DELAY_INS * INSTR_CYCLES;
    localparam int PRESCALE_W     = 11;
endpackage

//--- sim/tdrec_props.sv
// port assertions for the event / capture timer
`timescale 1ns/100ps
module tdrec_props (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        event_trigger_pin,
    input wire logic        timer_irq_flag,
    input wire logic        capture_status_flag,
    input wire logic        capture_error_flag,
    input wire logic        overflow_pulse
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    logic fw;
    // flag register write that commits at this edge
    assign fw = psel && penable && pwrite && paddr[7:2] == tdrec_pkg::IDX_FLAGS[5:0];

    property p_irq_hold;
        timer_irq_flag && !(fw && !pwdata[0]) |=> timer_irq_flag;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq flag dropped");
    property p_csf_hold;
        capture_status_flag && !(fw && !pwdata[1]) |=> capture_status_flag;
    endproperty
    a_csf_hold: assert property (p_csf_hold) else $error("status flag dropped");
    property p_cef_hold;
        capture_error_flag && !(fw && !pwdata[2]) |=> capture_error_flag;
    endproperty
    a_cef_hold: assert property (p_cef_hold) else $error("error flag dropped");
    property p_csf_clr;
        fw && !pwdata[1] |=> !capture_status_flag;
    endproperty
    a_csf_clr: assert property (p_csf_clr) else $error("status flag not cleared");
    property p_ovf_irq;
        overflow_pulse |-> timer_irq_flag;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow without irq");
    property p_ovf_one;
        overflow_pulse |=> !overflow_pulse;
    endproperty
    a_ovf_one: assert property (p_ovf_one) else $error("overflow pulse too long");
    property p_cs_irq;
        $rose(capture_status_flag) |-> timer_irq_flag;
    endproperty
    a_cs_irq: assert property (p_cs_irq) else $error("capture without irq");
    property p_cef_why;
        $rose(capture_error_flag) |->
            ($past(capture_status_flag) || overflow_pulse || $past(overflow_pulse));
    endproperty
    a_cef_why: assert property (p_cef_why) else $error("error flag without cause");
    // main scenarios reached
    c_ovf: cover property (overflow_pulse);
    c_cap: cover property ($rose(capture_status_flag));
    c_err: cover property ($rose(capture_error_flag));
endmodule

bind tdrec_timer tdrec_props tdrec_props_i (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_trigger_pin(event_trigger_pin), .timer_irq_flag(timer_irq_flag),
    .capture_status_flag(capture_status_flag), .capture_error_flag(capture_error_flag),
    .overflow_pulse(overflow_pulse));

//--- sim/tdrec_pin_model.sv
// far-side event source driving the trigger pin
`timescale 1ns/100ps
module tdrec_pin_model (
    input  wire logic sys_clk,
    output logic      pin
);
    // idle high between bursts
    initial pin = 1'b1;
    // each level held two instruction cycles or more, so slow gaps are allowed
    task automatic pulses(input int n, input int gap);
        int h;
        h = (gap < 2 * tdrec_pkg::INSTR_CYCLES) ? 2 * tdrec_pkg::INSTR_CYCLES : gap;
        repeat (n) begin
            pin <= 1'b0;
            repeat (h) @(posedge sys_clk);
            pin <= 1'b1;
            repeat (h) @(posedge sys_clk);
        end
    endtask
endmodule

//--- sim/tb_timer_d_reload_event_capture.sv
// self-checking bench for the event / capture timer
`timescale 1ns/100ps
module tb_timer_d_reload_event_capture;
    localparam logic [7:0] A_PF = tdrec_pkg::IDX_PORT_FUNC << 2;
    localparam logic [7:0] A_SB = tdrec_pkg::IDX_CLK_STBY << 2;
    localparam logic [7:0] A_MD = tdrec_pkg::IDX_MODE_SEL << 2;
    localparam logic [7:0] A_ED = tdrec_pkg::IDX_EDGE_SEL << 2;
    localparam logic [7:0] A_LO = tdrec_pkg::IDX_DIGIT_LOW << 2;
    localparam logic [7:0] A_HI = tdrec_pkg::IDX_DIGIT_HIGH << 2;
    localparam logic [7:0] A_FL = tdrec_pkg::IDX_FLAGS << 2;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        event_trigger_pin;
    logic        timer_irq_flag;
    logic        capture_status_flag;
    logic        capture_error_flag;
    logic        overflow_pulse;
    int          err_count = 0;
    int          tests_run = 0;
    int          n;
    logic [7:0]  v;
    logic [32:0] exp_q[$];
    string       nm_q[$];

    always #12.5 sys_clk = ~sys_clk;

    tdrec_timer tdrec_timer_i (.sys_clk(sys_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_trigger_pin(event_trigger_pin), .timer_irq_flag(timer_irq_flag),
        .capture_status_flag(capture_status_flag), .capture_error_flag(capture_error_flag),
        .overflow_pulse(overflow_pulse));
    tdrec_pin_model tdrec_pin_model_i (.sys_clk(sys_clk), .pin(event_trigger_pin));

    // each read answer is checked against the oldest note
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            tests_run++;
            if (exp_q.size() == 0 || {pslverr, prdata} !== exp_q[0]) begin
                err_count++;
                $display("[FAIL] %s exp %h got %h", nm_q[0], exp_q[0], {pslverr, prdata});
            end
            void'(exp_q.pop_front());
            void'(nm_q.pop_front());
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        if (i == 20) begin
            err_count++;
            $display("[FAIL] pready exp 1 got 0");
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e, input string s);
        exp_q.push_back(e);
        nm_q.push_back(s);
        xfer(1'b0, a, 32'h00000000);
    endtask
    // new mode only counts once the switch-over delay is over
    task automatic setm(input logic [3:0] m);
        wr(A_MD, {28'h0000000, m});
        repeat (tdrec_pkg::MODE_DELAY_CYC + 2) @(posedge sys_clk);
    endtask
    task automatic wait_ovf();
        int i;
        for (i = 0; i < 1000 && overflow_pulse !== 1'b1; i++) @(posedge sys_clk);
        if (i == 1000) begin
            err_count++;
            $display("[FAIL] overflow_pulse exp 1 got 0");
            summarize();
        end
    endtask

    initial begin
        void'($urandom(477));
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        // reset values, write-only read and refused index
        rd(A_FL, 33'h000000000, "flags");
        rd(A_MD, 33'h000000000, "mode");
        rd(A_ED, 33'h000000000, "edge");
        rd(8'h7C, 33'h100000000, "unmapped");
        $display("test reset done");
        // slow default source keeps the count still while digits are used
        v = 8'($urandom());
        wr(A_LO, {28'h0000000, v[3:0]});
        wr(A_HI, {28'h0000000, v[7:4]});
        wr(A_LO, {28'h0000000, ~v[3:0]});
        rd(A_HI, {29'h00000000, v[7:4]}, "count_high");
        rd(A_LO, {29'h00000000, v[3:0]}, "count_low");
        wr(A_HI, 32'h00000002);
        rd(A_HI, 33'h000000002, "reuse_high");
        rd(A_LO, {29'h00000000, ~v[3:0]}, "reuse_low");
        $display("test digits done");
        // free-running then reload overflow, fastest prescale
        for (int k = 0; k < 2; k++) begin
            setm(k ? 4'hE : 4'h6);
            wr(A_LO, 32'h00000008);
            wr(A_HI, 32'h0000000F);
            wait_ovf();
            rd(A_HI, k ? 33'h00000000F : 33'h000000000, "after_overflow");
            rd(A_FL, 33'h000000001, "irq_set");
            wr(A_FL, 32'h00000000);
            rd(A_FL, 33'h000000000, "irq_clear");
        end
        $display("test overflow done");
        // event counting on the falling, rising and both edge codes
        wr(A_PF, 32'h00000001);
        setm({1'b0, tdrec_pkg::SRC_EXTERNAL});
        wr(A_LO, 32'h00000000);
        for (int k = 1; k < 4; k++) begin
            wr(A_ED, 32'(k));
            wr(A_HI, 32'h00000000);
            n = 1 + $urandom() % 6;
            tdrec_pin_model_i.pulses(n, 8 + $urandom() % 8);
            v = (k == tdrec_pkg::EDGE_BOTH) ? 8'(2 * n) : 8'(n);
            rd(A_HI, {29'h00000000, v[7:4]}, "event_high");
            rd(A_LO, {29'h00000000, v[3:0]}, "event_low");
        end
        // stopped clock ignores the pin
        wr(A_HI, 32'h00000000);
        wr(A_SB, 32'h00000001);
        tdrec_pin_model_i.pulses(2, 8);
        rd(A_HI, 33'h000000000, "standby_high");
        rd(A_LO, 33'h000000000, "standby_low");
        wr(A_SB, 32'h00000000);
        $display("test event done");
        // capture: load 37, then entering capture must clear it
        // mid-run reset restarts the prescaler, so the slow internal source
        // cannot tick while the captured values are checked
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(A_FL, 33'h000000000, "reset_flags");
        wr(A_PF, 32'h00000001);
        setm(4'h0);
        wr(A_LO, 32'h00000007);
        wr(A_HI, 32'h00000003);
        wr(A_ED, 32'h00000005);
        tdrec_pin_model_i.pulses(1, 10);
        rd(A_LO, 33'h000000000, "cap0_low");
        rd(A_HI, 33'h000000000, "cap0_high");
        rd(A_FL, 33'h000000003, "cap_flags");
        wr(A_HI, 32'h00000004);
        wr(A_FL, 32'h00000005);
        tdrec_pin_model_i.pulses(1, 10);
        rd(A_LO, 33'h000000007, "cap1_low");
        rd(A_HI, 33'h000000004, "cap1_high");
        wr(A_FL, 32'h00000005);
        tdrec_pin_model_i.pulses(1, 10);
        rd(A_HI, 33'h000000000, "cap2_high");
        rd(A_LO, 33'h000000000, "cap2_low");
        tdrec_pin_model_i.pulses(1, 10);
        rd(A_FL, 33'h000000007, "err_flags");
        wr(A_FL, 32'h00000000);
        rd(A_FL, 33'h000000000, "flags_clear");
        $display("test capture done");
        summarize();
    end
endmodule
